// >>> rtl/srr_pkg.sv
// Shared constants and types for the status reporting register bank.
// Assumes one 250 MHz clock domain; bus pins are synchronised in the top module.
package srr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Address map of the 64-byte block in the upper quarter of A16 space
  localparam logic [1:0] A16_REGION_TOP = 2'b11; // 0xc000 region select
  localparam logic [15:0] A16_REGION_BASE = 16'hc000;
  localparam int BLOCK_SHIFT = 6; // 64 bytes per logical address
  localparam logic [7:0] LOGICAL_ADDRESS_FACTORY = 8'h08;
  localparam logic [5:0] OFF_SUMMARY = 6'h00;
  localparam logic [5:0] OFF_QUES = 6'h02;
  localparam logic [5:0] OFF_EVENT = 6'h04;

  ////////////////////////////////////////////////////////////////////////////
  // Summary status byte bit positions
  localparam int SB_QUES_BIT = 3;
  localparam int SB_EVENT_BIT = 5;
  localparam int SB_RSQ_BIT = 6;
  localparam logic [7:0] SB_USED_MASK = 8'h68;

  // Questionable signal bit positions
  localparam int QUES_INPUT_BIT = 9;
  localparam int QUES_OUTPUT_BIT = 10;
  localparam logic [15:0] QUES_USED_MASK = 16'h0600;
  localparam logic [15:0] QUES_RESET = 16'h0000;

  // Standard event bit positions
  localparam int EV_QUERY_BIT = 2;
  localparam int EV_DEVICE_BIT = 3;
  localparam int EV_EXEC_BIT = 4;
  localparam int EV_CMD_BIT = 5;
  localparam int EV_PON_BIT = 7;
  localparam logic [7:0] EV_USED_MASK = 8'hbc;
  localparam logic [7:0] EV_RESET = 8'h80; // Power-on flag set out of reset

  ////////////////////////////////////////////////////////////////////////////
  // Cycle counts
  localparam logic [1:0] LOGICAL_ADDRESS_CAPTURE_CYCLES = 2'd2; // Switch sync settle

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
  } srr_bus_req_t;

  typedef struct packed {
    logic query_error_flag;
    logic device_error_flag;
    logic execution_error_flag;
    logic command_error_flag;
  } srr_std_evt_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_HOLD = 1'b1
  } srr_state_t;

endpackage

// >>> rtl/srr_event_reg.sv
// Latched event register with enable mask and summary output.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/100ps
module srr_event_reg #(
  parameter int W = 8,
  parameter logic [W-1:0] RESET_VAL = '0,
  parameter logic [W-1:0] USED_MASK = '1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] set_bits,
  input wire logic clear,
  input wire logic [W-1:0] enable_mask,
  output logic [W-1:0] event_bits,
  output logic summary
);

  ////////////////////////////////////////////////////////////////////////////
  // One sticky bit per used position; unused positions are tied low
  for (genvar i = 0; i < W; i++) begin : g_bit
    if (USED_MASK[i]) begin : g_used
      logic bit_reg;
      logic bit_next;
      // Set beats clear so an event in the clearing cycle survives
      assign bit_next = set_bits[i] ? 1'b1 : (clear ? 1'b0 : bit_reg);
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          bit_reg <= RESET_VAL[i];
        end else if (ce) begin
          bit_reg <= bit_next;
        end
      end
      assign event_bits[i] = bit_reg;
    end else begin : g_unused
      assign event_bits[i] = 1'b0;
    end
  end

  // Summary is the OR of latched bits gated by the enable mask
  assign summary = |(event_bits & enable_mask);

endmodule

// >>> rtl/srr_regs.sv
// Status reporting register bank: summary byte, questionable and standard
// event registers behind an A16 read handshake, plus serial poll.
// Assumes bus and poll strobes are level handshakes from the controller
// pins; event pulses, enables and clear come from same-clock command logic.
//
// Functional notes
// - Summary bit 3: enabled questionable event latched
// - Summary bit 5: enabled standard event latched
// - Summary bit 6 service request, poll clears
// - Summary bits 0-2, 4, 7 read zero
// - Summary bits follow present summarized state
// - Questionable bit 9: input signal absent
// - Questionable bit 10: output absent, others zero
// - Event bits 0, 1, 6 read zero
// - Event bit 2: query error
// - Event bit 3: device dependent error
// - Event bit 4: execution error
// - Event bit 5: command error
// - Event bit 7 set after power on
// - Operation group never reports anything
// - No word serial; direct register reads only
// - Decode 64-byte block, three registers
// - Logical address defaults to eight
`timescale 1ns/100ps
module srr_regs
  import srr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire srr_bus_req_t a16_req,
  output logic [15:0] a16_rd_data,
  output logic a16_ack,
  input wire logic spoll_req,
  output logic [7:0] spoll_data,
  output logic spoll_ack,
  output logic srq_out,
  input wire logic [7:0] logical_address_switch,
  output logic [7:0] logical_address,
  input wire logic input_absent,
  input wire logic output_absent,
  input wire srr_std_evt_t std_evt,
  input wire logic clear_status,
  input wire logic [15:0] ques_enable,
  input wire logic [7:0] event_enable,
  input wire logic [7:0] srq_enable,
  output logic [7:0] summary_byte
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only stage two is read by any logic
  srr_bus_req_t req_s1_reg;
  srr_bus_req_t req_s2_reg;
  logic [1:0] poll_sync_reg;
  logic [7:0] logical_address_s1_reg;
  logic [7:0] logical_address_s2_reg;
  logic [1:0] in_abs_sync_reg;
  logic [1:0] out_abs_sync_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_s1_reg <= '0;
      req_s2_reg <= '0;
      poll_sync_reg <= 2'h0;
      logical_address_s1_reg <= 8'h00;
      logical_address_s2_reg <= 8'h00;
      in_abs_sync_reg <= 2'h0;
      out_abs_sync_reg <= 2'h0;
    end else if (ce) begin
      req_s1_reg <= a16_req;
      req_s2_reg <= req_s1_reg;
      poll_sync_reg <= {poll_sync_reg[0], spoll_req};
      logical_address_s1_reg <= logical_address_switch;
      logical_address_s2_reg <= logical_address_s1_reg;
      in_abs_sync_reg <= {in_abs_sync_reg[0], input_absent};
      out_abs_sync_reg <= {out_abs_sync_reg[0], output_absent};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Logical address: factory value until the switch has settled, then
  // tracks the synchronised switch every cycle; later switch moves need no reset
  logic [7:0] logical_address_reg;
  logic [7:0] logical_address_next;
  logic [1:0] logical_address_cnt_reg;
  logic [1:0] logical_address_cnt_next;
  logic logical_address_capture;

  assign logical_address_capture = (logical_address_cnt_reg == LOGICAL_ADDRESS_CAPTURE_CYCLES);
  assign logical_address_cnt_next = logical_address_capture ? logical_address_cnt_reg : logical_address_cnt_reg + 2'd1;
  assign logical_address_next = logical_address_capture ? logical_address_s2_reg : logical_address_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      logical_address_reg <= LOGICAL_ADDRESS_FACTORY;
      logical_address_cnt_reg <= 2'd0;
    end else if (ce) begin
      logical_address_reg <= logical_address_next;
      logical_address_cnt_reg <= logical_address_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode helpers; in_block serves reads and writes, is_reg only reads
  function automatic logic in_block(input logic [15:0] addr, input logic [7:0] la);
    in_block = (addr[15:14] == A16_REGION_TOP) && (addr[13:6] == la);
  endfunction

  function automatic logic is_reg(input logic [15:0] addr);
    is_reg = (addr[5:0] == OFF_SUMMARY) || (addr[5:0] == OFF_QUES) ||
             (addr[5:0] == OFF_EVENT);
  endfunction

  logic block_base_ok;
  logic rd_hit;
  logic wr_hit;
  logic [5:0] offset;

  // Base equals region start plus logical address shifted by block size
  assign block_base_ok = ({A16_REGION_TOP, logical_address_reg, 6'h00} ==
                          (A16_REGION_BASE + {2'b00, logical_address_reg, 6'h00}));
  assign rd_hit = req_s2_reg.rd && in_block(req_s2_reg.addr, logical_address_reg);
  assign wr_hit = req_s2_reg.wr && in_block(req_s2_reg.addr, logical_address_reg);
  assign offset = req_s2_reg.addr[5:0];

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: answer a strobe in our block, hold ack until it drops.
  // Requests outside the block get no answer so another module may reply.
  srr_state_t state_reg;
  srr_state_t state_next;
  logic take;
  logic rd_take;
  logic strobe_gone;

  assign take = (state_reg == ST_IDLE) && (rd_hit || wr_hit) && block_base_ok;
  assign rd_take = take && req_s2_reg.rd;
  assign strobe_gone = !req_s2_reg.rd && !req_s2_reg.wr;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (strobe_gone) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event registers
  logic [15:0] ques_set;
  logic [15:0] ques_bits;
  logic ques_clear;
  logic ques_summary;
  logic [7:0] ev_set;
  logic [7:0] ev_bits;
  logic ev_clear;
  logic ev_summary;

  // Signal loss sets while it lasts, so a read clears only if restored
  always_comb begin
    ques_set = 16'h0000;
    ques_set[QUES_INPUT_BIT] = in_abs_sync_reg[1];
    ques_set[QUES_OUTPUT_BIT] = out_abs_sync_reg[1];
  end

  // Error pulses from the command logic; bits 0, 1 and 6 never set
  always_comb begin
    ev_set = 8'h00;
    ev_set[EV_QUERY_BIT] = std_evt.query_error_flag;
    ev_set[EV_DEVICE_BIT] = std_evt.device_error_flag;
    ev_set[EV_EXEC_BIT] = std_evt.execution_error_flag;
    ev_set[EV_CMD_BIT] = std_evt.command_error_flag;
  end

  // Reading a register clears it, as does a status clear
  assign ques_clear = clear_status || (rd_take && offset == OFF_QUES);
  assign ev_clear = clear_status || (rd_take && offset == OFF_EVENT);

  srr_event_reg #(
    .W(16),
    .RESET_VAL(QUES_RESET),
    .USED_MASK(QUES_USED_MASK)
  ) u_ques (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .set_bits(ques_set),
    .clear(ques_clear),
    .enable_mask(ques_enable),
    .event_bits(ques_bits),
    .summary(ques_summary)
  );

  // Power-on flag comes from the reset value of bit 7
  srr_event_reg #(
    .W(8),
    .RESET_VAL(EV_RESET),
    .USED_MASK(EV_USED_MASK)
  ) u_event (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .set_bits(ev_set),
    .clear(ev_clear),
    .enable_mask(event_enable),
    .event_bits(ev_bits),
    .summary(ev_summary)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Service request: a new request latches the summary bit 6 flag,
  // a serial poll clears it; set wins when both land together
  logic [7:0] live_byte;
  logic request;
  logic request_d_reg;
  logic rsq_reg;
  logic rsq_next;
  logic poll_take;
  logic poll_busy_reg;
  logic poll_busy_next;

  // Live summary; unused and operation bits tied low
  always_comb begin
    live_byte = 8'h00;
    live_byte[SB_QUES_BIT] = ques_summary;
    live_byte[SB_EVENT_BIT] = ev_summary;
    live_byte[SB_RSQ_BIT] = rsq_reg;
  end

  assign request = |(live_byte & srq_enable & ~(8'h01 << SB_RSQ_BIT));
  assign poll_take = poll_sync_reg[1] && !poll_busy_reg;
  assign poll_busy_next = poll_sync_reg[1];
  assign rsq_next = (request && !request_d_reg) ? 1'b1 :
                    (poll_take ? 1'b0 : rsq_reg);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      request_d_reg <= 1'b0;
      rsq_reg <= 1'b0;
      poll_busy_reg <= 1'b0;
    end else if (ce) begin
      request_d_reg <= request;
      rsq_reg <= rsq_next;
      poll_busy_reg <= poll_busy_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data select; register-based only, no word serial engine
  logic [15:0] rd_word;

  assign rd_word = (offset == OFF_SUMMARY) ? {8'h00, live_byte & SB_USED_MASK} :
                   (offset == OFF_QUES) ? (ques_bits & QUES_USED_MASK) :
                   (offset == OFF_EVENT) ? {8'h00, ev_bits & EV_USED_MASK} :
                   16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs; summary byte is resampled every cycle so it never
  // holds a stale condition, at the cost of one cycle of lag
  logic [15:0] rd_data_reg;
  logic [15:0] rd_data_next;
  logic ack_reg;
  logic [7:0] poll_data_reg;
  logic [7:0] poll_data_next;
  logic poll_ack_reg;
  logic srq_reg;
  logic [7:0] summary_reg;

  // Writes are acknowledged with zero data; unmapped offsets read zero
  assign rd_data_next = rd_take ? (is_reg(offset) ? rd_word : 16'h0000) :
                        (take ? 16'h0000 : rd_data_reg);
  assign poll_data_next = poll_take ? (live_byte & SB_USED_MASK) : poll_data_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      rd_data_reg <= 16'h0000;
      ack_reg <= 1'b0;
      poll_data_reg <= 8'h00;
      poll_ack_reg <= 1'b0;
      srq_reg <= 1'b0;
      summary_reg <= 8'h00;
    end else if (ce) begin
      state_reg <= state_next;
      rd_data_reg <= rd_data_next;
      ack_reg <= (state_next == ST_HOLD);
      poll_data_reg <= poll_data_next;
      poll_ack_reg <= poll_busy_next;
      srq_reg <= rsq_next;
      summary_reg <= live_byte & SB_USED_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port drive; the mapped-controller view adds a fixed window offset of
  // 2080768 on the controller side and needs nothing here
  assign a16_rd_data = rd_data_reg;
  assign a16_ack = ack_reg;
  assign spoll_data = poll_data_reg;
  assign spoll_ack = poll_ack_reg;
  assign srq_out = srq_reg;
  assign logical_address = logical_address_reg;
  assign summary_byte = summary_reg;

endmodule

// >>> dv/srr_regs_checker.sv
// Checker for the status register bank, watching its top ports only.
// Assumes the bench holds ce high; bound in at the foot of this file.
`timescale 1ns/100ps
module srr_regs_checker
  import srr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire srr_bus_req_t a16_req,
  input wire logic [15:0] a16_rd_data,
  input wire logic a16_ack,
  input wire logic [7:0] spoll_data,
  input wire logic spoll_ack,
  input wire logic srq_out,
  input wire logic [7:0] logical_address,
  input wire logic input_absent,
  input wire srr_std_evt_t std_evt,
  input wire logic [15:0] ques_enable,
  input wire logic [7:0] event_enable,
  input wire logic [7:0] summary_byte
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Bits a read may carry, by offset; unknown offsets must read zero
  wire [5:0] off = a16_req.addr[5:0];
  wire [15:0] rd_mask = (off == OFF_QUES) ? QUES_USED_MASK :
    (off == OFF_EVENT) ? {8'h00, EV_USED_MASK} :
    (off == OFF_SUMMARY) ? {8'h00, SB_USED_MASK} : 16'h0000;
  ////////////////////////////////////////////////////////////
  // Steps: strobes released, a lasting loss, an enabled command error
  sequence pins_low_s;
    !(a16_req.rd || a16_req.wr) [*4];
  endsequence
  sequence loss_held_s;
    (ce && input_absent && ques_enable[QUES_INPUT_BIT]) [*6];
  endsequence
  sequence cmd_err_s;
    std_evt.command_error_flag && event_enable[EV_CMD_BIT] ##1 event_enable[EV_CMD_BIT];
  endsequence
  unused_zero_a: assert property ((summary_byte & ~SB_USED_MASK) == 8'h00)
    else $error("summary spare bits set");
  ques_sum_a: assert property (loss_held_s |-> summary_byte[SB_QUES_BIT])
    else $error("questionable summary missing");
  evt_sum_a: assert property (cmd_err_s |-> ##[0:1] summary_byte[SB_EVENT_BIT])
    else $error("event summary missing");
  ques_off_a: assert property (((ques_enable & QUES_USED_MASK) == 16'h0000) [*2]
    |-> !summary_byte[SB_QUES_BIT]) else $error("masked questionable shown");
  evt_off_a: assert property (((event_enable & EV_USED_MASK) == 8'h00) [*2]
    |-> !summary_byte[SB_EVENT_BIT]) else $error("masked event shown");
  ack_cause_a: assert property ($rose(a16_ack) |-> $past(a16_req.rd || a16_req.wr, 3)
    && $past(a16_req.addr[15:6], 3) == {A16_REGION_TOP, logical_address})
    else $error("ack without matching request");
  ack_drop_a: assert property (pins_low_s |=> !a16_ack)
    else $error("ack held after strobes dropped");
  // Only while the strobe stands: the released address is scrambled
  rd_mask_a: assert property (a16_ack && a16_req.rd |-> (a16_rd_data & ~rd_mask) == 16'h0000)
    else $error("unused read bits set");
  poll_clr_a: assert property ($rose(spoll_ack) |-> !srq_out
    && spoll_data[SB_RSQ_BIT] == $past(srq_out)) else $error("poll request flag wrong");
  logical_address_def_a: assert property ($fell(rst) |-> logical_address == LOGICAL_ADDRESS_FACTORY)
    else $error("logical address not default");
endmodule
bind srr_regs srr_regs_checker i_srr_regs_checker (.clk, .rst, .ce, .a16_req,
  .a16_rd_data, .a16_ack, .spoll_data, .spoll_ack, .srq_out, .logical_address,
  .input_absent, .std_evt, .ques_enable, .event_enable, .summary_byte);

// >>> dv/srr_ctrl_model.sv
// Controller model: direct register reads and serial polls, level handshake.
// Assumes the bench calls its tasks; every wait is bounded.
`timescale 1ns/100ps
module srr_ctrl_model
  import srr_pkg::*;
(
  input wire logic clk,
  output srr_bus_req_t a16_req,
  input wire logic [15:0] a16_rd_data,
  input wire logic a16_ack,
  output logic spoll_req,
  input wire logic [7:0] spoll_data,
  input wire logic spoll_ack
);
  initial begin
    a16_req = '{1'b0, 1'b0, 16'h0000};
    spoll_req = 1'b0;
  end
  // One transfer; only plain register access, never a message protocol
  task automatic xfer(input logic wr, input logic [7:0] la, input logic [5:0] offs,
                      output logic [15:0] d, output logic ok);
    logic [21:0] mapped;
    int n;
    // Mapped view; its low 16 bits are the direct address
    mapped = 22'h1fc000 + {8'h00, la, 6'h00} + {16'h0000, offs};
    ok = 1'b0;
    d = 16'h0000;
    @(posedge clk);
    #1;
    a16_req = '{rd: !wr, wr: wr, addr: mapped[15:0]};
    // Sample mid-cycle so a freshly launched ack is never raced at its edge
    for (n = 0; n < 12 && !ok; n++) begin
      @(negedge clk);
      ok = a16_ack;
      d = a16_rd_data;
    end
    // Strobe stands through the next rising edge with ack high
    @(posedge clk);
    #1;
    // Released address is scrambled so stale values are never trusted
    a16_req = '{rd: 1'b0, wr: 1'b0, addr: ~mapped[15:0]};
    for (n = 0; n < 12 && a16_ack; n++) @(negedge clk);
    // An ack that never drops fails the transfer
    if (a16_ack) ok = 1'b0;
  endtask
  // Serial poll: raise, take the byte with the ack, drop, await release
  task automatic poll(output logic [7:0] d, output logic ok);
    int n;
    ok = 1'b0;
    d = 8'h00;
    @(posedge clk);
    #1;
    spoll_req = 1'b1;
    for (n = 0; n < 12 && !ok; n++) begin
      @(negedge clk);
      ok = spoll_ack;
      d = spoll_data;
    end
    @(posedge clk);
    #1;
    spoll_req = 1'b0;
    for (n = 0; n < 12 && spoll_ack; n++) @(negedge clk);
    if (spoll_ack) ok = 1'b0;
  endtask
endmodule

// >>> dv/srr_regs_tb.sv
// Self-checking bench for the status register bank.
// Assumes the controller model above; ce is held high throughout.
`timescale 1ns/100ps
module srr_regs_tb
  import srr_pkg::*;
;
  logic clk, rst, ce, spoll_req, a16_ack, spoll_ack, srq_out, ok, pok;
  logic input_absent, output_absent, clear_status;
  logic [15:0] a16_rd_data, ques_enable, d;
  logic [7:0] spoll_data, logical_address_switch, logical_address, la, pd;
  logic [7:0] event_enable, srq_enable, summary_byte;
  logic [1:0] p;
  srr_bus_req_t a16_req;
  srr_std_evt_t std_evt;
  int errors, comparisons;
  srr_regs i_srr_regs (.clk, .rst, .ce, .a16_req, .a16_rd_data, .a16_ack, .spoll_req,
    .spoll_data, .spoll_ack, .srq_out, .logical_address_switch, .logical_address, .input_absent,
    .output_absent, .std_evt, .clear_status, .ques_enable, .event_enable, .srq_enable,
    .summary_byte);
  srr_ctrl_model i_srr_ctrl_model (.clk, .a16_req, .a16_rd_data, .a16_ack, .spoll_req,
    .spoll_data, .spoll_ack);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  // Expected values worked out from the bit maps
  function automatic logic [15:0] evt_exp(input int k);
    return 16'h0004 << k;
  endfunction
  function automatic logic [15:0] ques_exp(input logic [1:0] v);
    return {5'h00, v, 9'h000};
  endfunction
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Inputs change 1 ns after the edge so the design samples them cleanly
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rd(input string nm, input logic [5:0] o, input logic [15:0] e,
                    input logic wr = 1'b0);
    i_srr_ctrl_model.xfer(wr, la, o, d, ok);
    chk("ack", 16'h0001, {15'h0000, ok});
    chk(nm, e, d);
  endtask
  task automatic pulse(input int k);
    std_evt = srr_std_evt_t'(4'b1000 >> k);
    tick(1);
    std_evt = '0;
  endtask
  task automatic reset_with(input logic [7:0] sw);
    la = sw;
    logical_address_switch = sw;
    rst = 1'b1;
    tick(4);
    rst = 1'b0;
    tick(8);
  endtask
  task automatic wrap_up;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst, ce, input_absent, output_absent, clear_status} = 5'b11000;
    {ques_enable, event_enable, srq_enable} = '0;
    std_evt = '0;
    errors = 0;
    comparisons = 0;
    void'($urandom(99363));
    reset_with(LOGICAL_ADDRESS_FACTORY);
    chk("logical_address", {8'h00, LOGICAL_ADDRESS_FACTORY}, {8'h00, logical_address});
    rd("pon", OFF_EVENT, 16'h0080);
    rd("evt cleared", OFF_EVENT, 16'h0000);
    rd("summary", OFF_SUMMARY, 16'h0000);
    rd("spare", 6'h06, 16'h0000);
    rd("write", OFF_EVENT, 16'h0000, 1'b1);
    i_srr_ctrl_model.xfer(1'b0, la + 8'h01, OFF_SUMMARY, d, ok);
    chk("foreign ack", 16'h0000, {15'h0000, ok});
    // Every error source lands in its own bit
    for (int k = 0; k < 4; k++) begin
      pulse(k);
      rd("evt", OFF_EVENT, evt_exp(k));
    end
    // Random losses; latch persists past restore until read once
    for (int i = 0; i < 4; i++) begin
      p = 2'($urandom);
      {output_absent, input_absent} = p;
      tick(6);
      rd("ques", OFF_QUES, ques_exp(p));
      {output_absent, input_absent} = 2'b00;
      tick(6);
      rd("ques latched", OFF_QUES, ques_exp(p));
      rd("ques clear", OFF_QUES, 16'h0000);
    end
    ques_enable = 16'h0600;
    input_absent = 1'b1;
    tick(8);
    chk("sum ques", 16'h0008, {8'h00, summary_byte});
    rd("sum bus", OFF_SUMMARY, 16'h0008);
    ques_enable = 16'h0000;
    tick(2);
    chk("sum live", 16'h0000, {8'h00, summary_byte});
    input_absent = 1'b0;
    tick(6);
    rd("ques drain", OFF_QUES, 16'h0200);
    event_enable = 8'h20;
    srq_enable = 8'h20;
    tick(1);
    pulse(3);
    tick(3);
    chk("sum evt", 16'h0060, {8'h00, summary_byte});
    i_srr_ctrl_model.poll(pd, pok);
    chk("poll", 16'h0160, {7'h00, pok, pd});
    tick(1);
    chk("srq", 16'h0020, {7'h00, srq_out, summary_byte});
    clear_status = 1'b1;
    tick(1);
    clear_status = 1'b0;
    tick(2);
    chk("cleared", 16'h0000, {8'h00, summary_byte});
    // Second reset from a random switch setting
    reset_with(8'($urandom));
    chk("logical_address sw", {8'h00, la}, {8'h00, logical_address});
    rd("pon again", OFF_EVENT, 16'h0080);
    wrap_up();
  end
endmodule
